// >>> wfm_pkg.sv
/*
  Constants, register map and carrier types of the wake-frame match register bank.
  Assumes a single 50 MHz clock shared by the host register port and the receive byte stream.
*/
package wfm_pkg;

  localparam int DATA_W = 16;
  localparam int ADDR_W = 8;
  localparam int NUM_ENABLE_PATTERNS = 4;
  localparam int NUM_STORED_PATTERNS = 2;
  localparam int WORDS_PER_PATTERN = 6;
  localparam int NUM_PATTERN_WORDS = 12;
  localparam int MASK_WORDS = 4;
  localparam int MASK_BYTES = 64;

  // Register byte addresses.
  localparam logic [7:0] ADDR_WAKE_DETECT_CONTROL = 8'h2a;
  localparam logic [7:0] ADDR_PATTERN0_CRC_LOW = 8'h30;
  localparam logic [7:0] ADDR_PATTERN0_CRC_HIGH = 8'h32;
  localparam logic [7:0] ADDR_PATTERN0_MASK_BYTES_1_16 = 8'h34;
  localparam logic [7:0] ADDR_PATTERN0_MASK_BYTES_17_32 = 8'h36;
  localparam logic [7:0] ADDR_PATTERN0_MASK_BYTES_33_48 = 8'h38;
  localparam logic [7:0] ADDR_PATTERN0_MASK_BYTES_49_64 = 8'h3a;
  localparam logic [7:0] ADDR_PATTERN1_CRC_LOW = 8'h40;
  localparam logic [7:0] ADDR_PATTERN1_CRC_HIGH = 8'h42;
  localparam logic [7:0] ADDR_PATTERN1_MASK_BYTES_1_16 = 8'h44;
  localparam logic [7:0] ADDR_PATTERN1_MASK_BYTES_17_32 = 8'h46;
  localparam logic [7:0] ADDR_PATTERN1_MASK_BYTES_33_48 = 8'h48;
  localparam logic [7:0] ADDR_PATTERN1_MASK_BYTES_49_64 = 8'h4a;

  // Word slots inside the pattern storage; each pattern owns six consecutive slots.
  localparam logic [3:0] SLOT_CRC_LOW = 4'h0;
  localparam logic [3:0] SLOT_CRC_HIGH = 4'h1;
  localparam logic [3:0] SLOT_MASK0 = 4'h2;
  localparam logic [3:0] SLOT_MASK1 = 4'h3;
  localparam logic [3:0] SLOT_MASK2 = 4'h4;
  localparam logic [3:0] SLOT_MASK3 = 4'h5;
  localparam logic [3:0] SLOT_PATTERN1_BASE = 4'h6;
  localparam logic [3:0] SLOT_CONTROL = 4'hc;
  localparam logic [3:0] SLOT_NONE = 4'hf;

  // Control register fields.
  localparam int CTRL_SIGNATURE_EN_BIT = 7;
  localparam int CTRL_PATTERN3_EN_BIT = 3;
  localparam int CTRL_PATTERN2_EN_BIT = 2;
  localparam int CTRL_PATTERN1_EN_BIT = 1;
  localparam int CTRL_PATTERN0_EN_BIT = 0;
  localparam logic [15:0] CTRL_WRITABLE_MASK = 16'h008f;
  localparam logic [15:0] CTRL_RESET = 16'h0000;
  localparam logic [15:0] PATTERN_WORD_RESET = 16'h0000;
  localparam logic [15:0] UNMAPPED_READ_VALUE = 16'h0000;

  // Ethernet CRC-32, bit-reflected form, as the receive path shifts bytes LSB first.
  localparam logic [31:0] CRC_POLY_REFLECTED = 32'hedb88320;
  localparam logic [31:0] CRC_INIT = 32'hffffffff;
  localparam logic [6:0] BYTE_INDEX_RESET = 7'h00;
  localparam logic [6:0] BYTE_INDEX_LIMIT = 7'h40;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [1:0] be;
    logic [15:0] wdata;
  } wfm_reg_req_t;

  typedef struct packed {
    logic valid;
    logic sof;
    logic eof;
    logic frame_ok;
    logic [7:0] data;
  } wfm_rx_byte_t;

  typedef struct packed {
    logic [31:0] expected;
    logic [63:0] mask;
  } wfm_pattern_cfg_t;

endpackage : wfm_pkg

// >>> wfm_pattern_crc_check.sv
/*
  One stored-pattern detector: CRC-32 over the mask-selected bytes among the first 64 of a frame.
  Assumes the receive bytes arrive on the same clock, at most one per cycle, framed by sof and eof.
*/
`timescale 1ns/100ps
module wfm_pattern_crc_check (
  // Clock and reset
  input wire logic clk_in,
  input wire logic arst_n_in,
  input wire logic soft_rst_in,
  // Configuration
  input wire logic enable_in,
  input wire wfm_pkg::wfm_pattern_cfg_t cfg_in,
  // Receive stream
  input wire wfm_pkg::wfm_rx_byte_t rx_in,
  // Result
  output logic match_out
);

  function automatic logic [31:0] crc_byte(input logic [31:0] crc, input logic [7:0] d);
    logic [31:0] c;
    c = crc;
    for (int i = 0; i < 8; i++) begin
      if (c[0] ^ d[i]) begin
        c = (c >> 1) ^ wfm_pkg::CRC_POLY_REFLECTED;
      end else begin
        c = c >> 1;
      end
    end
    return c;
  endfunction : crc_byte

  logic [31:0] crc;
  logic [6:0] byte_idx;
  logic in_frame;

  // A frame starts only on sof; stray bytes outside a frame are ignored.
  wire logic accept = rx_in.valid && (rx_in.sof || in_frame);
  wire logic [31:0] cur_crc = rx_in.sof ? wfm_pkg::CRC_INIT : crc;
  wire logic [6:0] cur_idx = rx_in.sof ? wfm_pkg::BYTE_INDEX_RESET : byte_idx;
  wire logic in_window = cur_idx < wfm_pkg::BYTE_INDEX_LIMIT;
  // Mask bit n selects frame byte n+1, so bit 0 of the first word is the first byte.
  wire logic take = in_window && cfg_in.mask[cur_idx[5:0]];
  wire logic [31:0] next_crc = take ? crc_byte(cur_crc, rx_in.data) : cur_crc;
  wire logic [6:0] next_idx = in_window ? 7'(cur_idx + 7'h01) : cur_idx;
  wire logic [31:0] final_crc = ~next_crc;
  wire logic frame_done = accept && rx_in.eof;
  wire logic next_match = frame_done && rx_in.frame_ok && enable_in && (final_crc == cfg_in.expected);

  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      crc <= wfm_pkg::CRC_INIT;
      byte_idx <= wfm_pkg::BYTE_INDEX_RESET;
      in_frame <= 1'b0;
      match_out <= 1'b0;
    end else if (soft_rst_in) begin
      crc <= wfm_pkg::CRC_INIT;
      byte_idx <= wfm_pkg::BYTE_INDEX_RESET;
      in_frame <= 1'b0;
      match_out <= 1'b0;
    end else begin
      if (accept) begin
        crc <= next_crc;
        byte_idx <= next_idx;
        in_frame <= !rx_in.eof;
      end
      match_out <= next_match;
    end
  end

endmodule : wfm_pattern_crc_check

// >>> wfm_wakeup_frame_match_regs.sv
/*
  Wake-frame match register bank: control word, expected CRC and byte masks for patterns zero and one,
  and the two stored-pattern detectors they steer.
  Assumes the host register port and the receive byte stream are produced by logic on REF_CLK_IN,
  so no synchroniser is needed; the soft reset is a synchronous pulse from the global reset register.
*/
`timescale 1ns/100ps
module wfm_wakeup_frame_match_regs (
  // Clock and reset
  input wire logic REF_CLK_IN,
  input wire logic ARST_N_IN,
  input wire logic SOFT_RST_IN,
  // Host register port
  input wire wfm_pkg::wfm_reg_req_t REG_REQ_IN,
  output logic [15:0] REG_RDATA_OUT,
  output logic REG_RVALID_OUT,
  // Receive byte stream
  input wire wfm_pkg::wfm_rx_byte_t RX_IN,
  // Detector enables and results
  output logic SIGNATURE_PACKET_DETECT_EN_OUT,
  output logic [3:0] PATTERN_DETECT_EN_OUT,
  output logic [1:0] WAKE_MATCH_OUT
);

  // Maps a byte address onto a storage slot; odd and unlisted addresses fall to SLOT_NONE.
  function automatic logic [3:0] slot_of(input logic [7:0] addr);
    logic [3:0] s;
    s = wfm_pkg::SLOT_NONE;
    case (addr)
      wfm_pkg::ADDR_WAKE_DETECT_CONTROL: begin
        s = wfm_pkg::SLOT_CONTROL;
      end
      wfm_pkg::ADDR_PATTERN0_CRC_LOW: begin
        s = wfm_pkg::SLOT_CRC_LOW;
      end
      wfm_pkg::ADDR_PATTERN0_CRC_HIGH: begin
        s = wfm_pkg::SLOT_CRC_HIGH;
      end
      wfm_pkg::ADDR_PATTERN0_MASK_BYTES_1_16: begin
        s = wfm_pkg::SLOT_MASK0;
      end
      wfm_pkg::ADDR_PATTERN0_MASK_BYTES_17_32: begin
        s = wfm_pkg::SLOT_MASK1;
      end
      wfm_pkg::ADDR_PATTERN0_MASK_BYTES_33_48: begin
        s = wfm_pkg::SLOT_MASK2;
      end
      wfm_pkg::ADDR_PATTERN0_MASK_BYTES_49_64: begin
        s = wfm_pkg::SLOT_MASK3;
      end
      wfm_pkg::ADDR_PATTERN1_CRC_LOW: begin
        s = 4'(wfm_pkg::SLOT_PATTERN1_BASE + wfm_pkg::SLOT_CRC_LOW);
      end
      wfm_pkg::ADDR_PATTERN1_CRC_HIGH: begin
        s = 4'(wfm_pkg::SLOT_PATTERN1_BASE + wfm_pkg::SLOT_CRC_HIGH);
      end
      wfm_pkg::ADDR_PATTERN1_MASK_BYTES_1_16: begin
        s = 4'(wfm_pkg::SLOT_PATTERN1_BASE + wfm_pkg::SLOT_MASK0);
      end
      wfm_pkg::ADDR_PATTERN1_MASK_BYTES_17_32: begin
        s = 4'(wfm_pkg::SLOT_PATTERN1_BASE + wfm_pkg::SLOT_MASK1);
      end
      wfm_pkg::ADDR_PATTERN1_MASK_BYTES_33_48: begin
        s = 4'(wfm_pkg::SLOT_PATTERN1_BASE + wfm_pkg::SLOT_MASK2);
      end
      wfm_pkg::ADDR_PATTERN1_MASK_BYTES_49_64: begin
        s = 4'(wfm_pkg::SLOT_PATTERN1_BASE + wfm_pkg::SLOT_MASK3);
      end
      default: begin
        s = wfm_pkg::SLOT_NONE;
      end
    endcase
    return s;
  endfunction : slot_of

  // Applies the two byte enables of a 16-bit write to an old word.
  function automatic logic [15:0] merge_bytes(input logic [15:0] old, input logic [15:0] wdata,
                                              input logic [1:0] be);
    logic [15:0] r;
    r = old;
    if (be[0]) begin
      r[7:0] = wdata[7:0];
    end
    if (be[1]) begin
      r[15:8] = wdata[15:8];
    end
    return r;
  endfunction : merge_bytes

  logic [15:0] ctrl;
  logic [15:0] pattern_word [wfm_pkg::NUM_PATTERN_WORDS];
  logic [15:0] rdata;
  logic rvalid;

  // Address decode, shared by the write and read paths.
  wire logic [3:0] slot = slot_of(REG_REQ_IN.addr);
  wire logic hit_ctrl = slot == wfm_pkg::SLOT_CONTROL;
  wire logic hit_pattern = slot < 4'(wfm_pkg::NUM_PATTERN_WORDS);
  wire logic wr_ctrl = REG_REQ_IN.wr && hit_ctrl;
  wire logic wr_pattern = REG_REQ_IN.wr && hit_pattern;

  // Only the five enable bits store; everything else of the control word stays zero.
  wire logic [15:0] ctrl_merged = merge_bytes(ctrl, REG_REQ_IN.wdata, REG_REQ_IN.be);
  wire logic [15:0] next_ctrl = ctrl_merged & wfm_pkg::CTRL_WRITABLE_MASK;
  wire logic [15:0] pattern_old = hit_pattern ? pattern_word[slot] : wfm_pkg::PATTERN_WORD_RESET;
  wire logic [15:0] next_pattern_word = merge_bytes(pattern_old, REG_REQ_IN.wdata, REG_REQ_IN.be);

  // Read selection; unmapped and reserved addresses read as zero.
  wire logic [15:0] read_pattern = hit_pattern ? pattern_word[slot] : wfm_pkg::UNMAPPED_READ_VALUE;
  wire logic [15:0] next_rdata = hit_ctrl ? (ctrl & wfm_pkg::CTRL_WRITABLE_MASK) : read_pattern;

  always_ff @(posedge REF_CLK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      ctrl <= wfm_pkg::CTRL_RESET;
    end else if (SOFT_RST_IN) begin
      ctrl <= wfm_pkg::CTRL_RESET;
    end else if (wr_ctrl) begin
      ctrl <= next_ctrl;
    end
  end

  always_ff @(posedge REF_CLK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      for (int i = 0; i < wfm_pkg::NUM_PATTERN_WORDS; i++) begin
        pattern_word[i] <= wfm_pkg::PATTERN_WORD_RESET;
      end
    end else if (SOFT_RST_IN) begin
      for (int i = 0; i < wfm_pkg::NUM_PATTERN_WORDS; i++) begin
        pattern_word[i] <= wfm_pkg::PATTERN_WORD_RESET;
      end
    end else if (wr_pattern) begin
      pattern_word[slot] <= next_pattern_word;
    end
  end

  // A read answers one cycle later; a write in the same cycle is not yet visible.
  always_ff @(posedge REF_CLK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      rdata <= wfm_pkg::UNMAPPED_READ_VALUE;
      rvalid <= 1'b0;
    end else begin
      rvalid <= REG_REQ_IN.rd;
      if (REG_REQ_IN.rd) begin
        rdata <= next_rdata;
      end
    end
  end

  assign REG_RDATA_OUT = rdata;
  assign REG_RVALID_OUT = rvalid;

  // Enable outputs come straight from the control flops.
  assign SIGNATURE_PACKET_DETECT_EN_OUT = ctrl[wfm_pkg::CTRL_SIGNATURE_EN_BIT];
  assign PATTERN_DETECT_EN_OUT[3] = ctrl[wfm_pkg::CTRL_PATTERN3_EN_BIT];
  assign PATTERN_DETECT_EN_OUT[2] = ctrl[wfm_pkg::CTRL_PATTERN2_EN_BIT];
  assign PATTERN_DETECT_EN_OUT[1] = ctrl[wfm_pkg::CTRL_PATTERN1_EN_BIT];
  assign PATTERN_DETECT_EN_OUT[0] = ctrl[wfm_pkg::CTRL_PATTERN0_EN_BIT];

  // Assemble each stored pattern: low CRC word in bits 15:0, first mask word covers bytes 1 to 16.
  wfm_pkg::wfm_pattern_cfg_t pattern_cfg [wfm_pkg::NUM_STORED_PATTERNS];
  logic [wfm_pkg::NUM_STORED_PATTERNS-1:0] pattern_en;

  assign pattern_en[0] = ctrl[wfm_pkg::CTRL_PATTERN0_EN_BIT];
  assign pattern_en[1] = ctrl[wfm_pkg::CTRL_PATTERN1_EN_BIT];

  for (genvar p = 0; p < wfm_pkg::NUM_STORED_PATTERNS; p++) begin : g_pattern
    localparam int BASE = p * wfm_pkg::WORDS_PER_PATTERN;
    assign pattern_cfg[p].expected = {pattern_word[BASE + 1], pattern_word[BASE]};
    assign pattern_cfg[p].mask = {pattern_word[BASE + 5], pattern_word[BASE + 4],
                                  pattern_word[BASE + 3], pattern_word[BASE + 2]};

    // The detector uses whatever values are stored; the host loads them before enabling.
    wfm_pattern_crc_check u_check (
      .clk_in(REF_CLK_IN),
      .arst_n_in(ARST_N_IN),
      .soft_rst_in(SOFT_RST_IN),
      .enable_in(pattern_en[p]),
      .cfg_in(pattern_cfg[p]),
      .rx_in(RX_IN),
      .match_out(WAKE_MATCH_OUT[p])
    );
  end

endmodule : wfm_wakeup_frame_match_regs

// >>> wfm_regs_sva.sv
/*
  Port assertions for the wake-frame match register bank.
  Assumes it is bound to the bank top, which has one clock and an asynchronous reset.
*/
`timescale 1ns/100ps
module wfm_regs_sva (
  // Clock and reset
  input wire logic REF_CLK_IN,
  input wire logic ARST_N_IN,
  input wire logic SOFT_RST_IN,
  // Register port
  input wire wfm_pkg::wfm_reg_req_t REG_REQ_IN,
  input wire logic [15:0] REG_RDATA_OUT,
  input wire logic REG_RVALID_OUT,
  // Receive stream and results
  input wire wfm_pkg::wfm_rx_byte_t RX_IN,
  input wire logic SIGNATURE_PACKET_DETECT_EN_OUT,
  input wire logic [3:0] PATTERN_DETECT_EN_OUT,
  input wire logic [1:0] WAKE_MATCH_OUT
);
  default clocking @(posedge REF_CLK_IN); endclocking
  default disable iff (!ARST_N_IN);
  sequence s_ctrl_wr;
    REG_REQ_IN.wr && REG_REQ_IN.be[0] && REG_REQ_IN.addr == 8'h2a && !SOFT_RST_IN;
  endsequence
  sequence s_good_end;
    RX_IN.valid && RX_IN.eof && RX_IN.frame_ok;
  endsequence
  chk_read_answer: assert property (REG_REQ_IN.rd |=> REG_RVALID_OUT)
    else $error("read not answered after one cycle");
  chk_rvalid_cause: assert property (REG_RVALID_OUT |-> $past(REG_REQ_IN.rd))
    else $error("read valid without a read");
  property p_pattern_en;
    s_ctrl_wr |=> PATTERN_DETECT_EN_OUT == $past(REG_REQ_IN.wdata[3:0]);
  endproperty
  property p_signature_en;
    s_ctrl_wr |=> SIGNATURE_PACKET_DETECT_EN_OUT == $past(REG_REQ_IN.wdata[7]);
  endproperty
  property p_reserved_zero;
    REG_REQ_IN.rd && REG_REQ_IN.addr == 8'h2a |=> (REG_RDATA_OUT & 16'hff70) == 16'h0000;
  endproperty
  property p_match_cause;
    WAKE_MATCH_OUT[0] |-> $past(PATTERN_DETECT_EN_OUT[0] && RX_IN.valid && RX_IN.eof && RX_IN.frame_ok);
  endproperty
  property p_unmapped_zero;
    REG_REQ_IN.rd && REG_REQ_IN.addr inside {8'h2c, 8'h3c, 8'h4c} |=> REG_RDATA_OUT == 16'h0000;
  endproperty
  chk_pattern_en: assert property (p_pattern_en)
    else $error("pattern enables differ from written control");
  chk_signature_en: assert property (p_signature_en)
    else $error("signature enable differs from written control");
  chk_reserved_zero: assert property (p_reserved_zero)
    else $error("reserved control bits read nonzero");
  chk_soft_clear: assert property (SOFT_RST_IN |=> PATTERN_DETECT_EN_OUT == 4'h0 && !SIGNATURE_PACKET_DETECT_EN_OUT)
    else $error("soft reset left enables set");
  chk_match_cause: assert property (p_match_cause)
    else $error("pattern zero match without enabled good frame end");
  chk_match_off: assert property ((s_good_end ##0 !PATTERN_DETECT_EN_OUT[1]) |=> !WAKE_MATCH_OUT[1])
    else $error("disabled pattern one reported a match");
  chk_unmapped_zero: assert property (p_unmapped_zero)
    else $error("reserved address read nonzero");
endmodule : wfm_regs_sva

bind wfm_wakeup_frame_match_regs wfm_regs_sva u_chk (.REF_CLK_IN(REF_CLK_IN), .ARST_N_IN(ARST_N_IN),
  .SOFT_RST_IN(SOFT_RST_IN), .REG_REQ_IN(REG_REQ_IN), .REG_RDATA_OUT(REG_RDATA_OUT), .REG_RVALID_OUT(REG_RVALID_OUT),
  .RX_IN(RX_IN), .SIGNATURE_PACKET_DETECT_EN_OUT(SIGNATURE_PACKET_DETECT_EN_OUT),
  .PATTERN_DETECT_EN_OUT(PATTERN_DETECT_EN_OUT), .WAKE_MATCH_OUT(WAKE_MATCH_OUT));

// >>> wfm_rx_src.sv
/*
  Receive-path model: sends one frame, a byte per cycle.
  Assumes send is entered just after a rising edge.
*/
`timescale 1ns/100ps
module wfm_rx_src (
  // Clock
  input wire logic clk_in,
  // Receive stream
  output wfm_pkg::wfm_rx_byte_t rx_out
);
  initial rx_out = '0;
  // Between frames the data lines show the inverse of the last byte, so nothing can lean on a stale byte.
  task automatic send(input logic [7:0] q[$], input logic ok);
    foreach (q[i]) begin
      @(posedge clk_in);
      #1;
      rx_out = '{valid: 1'b1, sof: i == 0, eof: i == q.size() - 1, frame_ok: ok && i == q.size() - 1, data: q[i]};
    end
    @(posedge clk_in);
    #1;
    rx_out = '{valid: 1'b0, sof: 1'b0, eof: 1'b0, frame_ok: 1'b0, data: ~rx_out.data};
  endtask : send
endmodule : wfm_rx_src

// >>> tb_top.sv
/*
  Self-checking bench of the wake-frame match register bank against a register and CRC model.
  Assumes the receive model and the bound checker are compiled with it.
*/
`timescale 1ns/100ps
module tb_top;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic soft_rst = 1'b0;
  wfm_pkg::wfm_reg_req_t req = '0;
  wfm_pkg::wfm_rx_byte_t rx;
  logic [15:0] rdata;
  logic rvalid;
  logic sig_en;
  logic [3:0] pat_en;
  logic [1:0] match;
  int error_cnt = 0;
  int check_count = 0;
  int mdl [0:127];
  logic [31:0] seed = 32'h00004403;

  always #10 clk = ~clk;

  wfm_wakeup_frame_match_regs DUT (.REF_CLK_IN(clk), .ARST_N_IN(arst_n), .SOFT_RST_IN(soft_rst), .REG_REQ_IN(req),
    .REG_RDATA_OUT(rdata), .REG_RVALID_OUT(rvalid), .RX_IN(rx), .SIGNATURE_PACKET_DETECT_EN_OUT(sig_en),
    .PATTERN_DETECT_EN_OUT(pat_en), .WAKE_MATCH_OUT(match));
  wfm_rx_src rxm (.clk_in(clk), .rx_out(rx));

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd

  function automatic logic [31:0] crc_of(input logic [7:0] q[$], input logic [63:0] m);
    logic [31:0] c;
    c = 32'hffffffff;
    for (int i = 0; i < q.size() && i < 64; i++) begin
      if (m[i]) begin
        c ^= {24'h000000, q[i]};
        for (int k = 0; k < 8; k++) c = c[0] ? (c >> 1) ^ 32'hedb88320 : c >> 1;
      end
    end
    return ~c;
  endfunction : crc_of

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
    check_count++;
    if (s !== e) begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", n, e, s);
    end
  endtask : chk

  task automatic complete_run();
    if (error_cnt == 0 && check_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : complete_run

  task automatic acc(input logic w, input logic [7:0] a, input logic [1:0] b, input logic [15:0] d);
    logic [15:0] m;
    @(posedge clk);
    #1;
    req = '{wr: w, rd: !w, addr: a, be: b, wdata: d};
    @(posedge clk);
    #1;
    req = '0;
    m = {{8{b[1]}}, {8{b[0]}}} & (a == 8'h2a ? 16'h008f : 16'hffff);
    if (!w) chk("read data", 32'(mdl[a]), 32'(rdata));
    if (!w) chk("read valid", 32'h00000001, 32'(rvalid));
    if (w && (a == 8'h2a || (!a[0] && a inside {[8'h30:8'h3a], [8'h40:8'h4a]}))) mdl[a] = (mdl[a] & ~m) | (d & m);
    chk("pattern enables", 32'(mdl[8'h2a][3:0]), 32'(pat_en));
    chk("signature enable", 32'(mdl[8'h2a][7]), 32'(sig_en));
  endtask : acc

  task automatic sweep();
    for (int a = 8'h28; a < 8'h50; a++) acc(1'b0, 8'(a), 2'b11, 16'h0000);
  endtask : sweep

  task automatic frame_run();
    logic [7:0] q[$];
    logic [63:0] m [2];
    logic [31:0] c;
    logic ok;
    repeat (1 + rnd() % 80) q.push_back(8'(rnd()));
    for (int p = 0; p < 2; p++) begin
      for (int w = 0; w < 4; w++) begin
        acc(1'b1, 8'(8'h34 + p * 16 + w * 2), 2'(rnd()), 16'(rnd()));
        m[p][w * 16 +: 16] = 16'(mdl[8'h34 + p * 16 + w * 2]);
      end
      c = crc_of(q, m[p]) ^ (rnd() % 4 == 0 ? 32'h00000001 << (rnd() % 32) : 32'h00000000);
      acc(1'b1, 8'(8'h30 + p * 16), 2'b11, c[15:0]);
      acc(1'b1, 8'(8'h32 + p * 16), 2'b11, c[31:16]);
    end
    acc(1'b1, 8'h2a, 2'(rnd()), 16'(rnd()));
    ok = rnd() % 5 != 0;
    rxm.send(q, ok);
    for (int p = 0; p < 2; p++) begin
      c = {16'(mdl[8'h32 + p * 16]), 16'(mdl[8'h30 + p * 16])};
      chk("wake match", 32'(mdl[8'h2a][p] && ok && c == crc_of(q, m[p])), 32'(match[p]));
    end
  endtask : frame_run

  initial begin
    foreach (mdl[i]) mdl[i] = 0;
    repeat (3) @(posedge clk);
    #1;
    arst_n = 1'b1;
    sweep();
    repeat (60) acc(1'(rnd()), 8'(8'h28 + rnd() % 40), 2'(rnd()), 16'(rnd()));
    repeat (20) frame_run();
    soft_rst = 1'b1;
    @(posedge clk);
    #1;
    soft_rst = 1'b0;
    foreach (mdl[i]) mdl[i] = 0;
    sweep();
    repeat (10) frame_run();
    arst_n = 1'b0;
    repeat (2) @(posedge clk);
    #1;
    arst_n = 1'b1;
    foreach (mdl[i]) mdl[i] = 0;
    sweep();
    complete_run();
  end

  initial begin
    repeat (30000) @(posedge clk);
    chk("run time", 32'h00000000, 32'h00000001);
    complete_run();
  end
endmodule : tb_top
